/* File: core/slvc_defines.svh */
`ifndef SLVC_DEFINES_SVH
`define SLVC_DEFINES_SVH

// register offsets (byte addresses, one dword each)
`define SLVC_OFF_SLOT        8'hC8
`define SLVC_OFF_LT0         8'hCC
`define SLVC_OFF_LT1         8'hD0
`define SLVC_OFF_LT2         8'hD4
`define SLVC_OFF_VPD_CTRL    8'hD8
`define SLVC_OFF_PRODUCT_DATA_WORD    8'hDC

// reset values
`define SLVC_SLOT_CTRL_RST   16'h0000
`define SLVC_LT0_RST         32'h0400_1060
`define SLVC_LT1_RST         32'h0000_0000
`define SLVC_LT2_RST         24'h19_0254
`define SLVC_WAIT_RST        8'h00
`define SLVC_WAIT_MS_RST     9'h080
`define SLVC_PRODUCT_DATA_WORD_RST    32'h0000_0000

// writable bits; everything else is reserved and reads zero
`define SLVC_SLOT_CTRL_WMASK 16'h07FF
`define SLVC_LT0_WMASK       32'hFFFF_1FFF
`define SLVC_LT1_WMASK       32'hFFFF_03FF
`define SLVC_D4_WMASK        32'hFF7F_FFFF

// fixed capability header
`define SLVC_VPD_CAP_ID      8'h03
`define SLVC_VPD_NEXT_PTR    8'hF0
`define SLVC_EEPROM_BASE     9'h040

// field positions
`define SLVC_SLOT_HP_INT_EN  5
`define SLVC_LT0_CROSS_LINK  2
`define SLVC_LT0_GOTO_CFG    3
`define SLVC_LT0_DEBUG_SEL   4
`define SLVC_LT2_RX_INVERT   15
`define SLVC_VPD_ADDR_LSB    18
`define SLVC_VPD_ADDR_MSB    23
`define SLVC_VPD_OP_BIT      31

`endif

/* File: core/slvc_pkg.sv */
package slvc_pkg;

  typedef enum logic [1:0] {
    VPD_IDLE = 2'b01,
    VPD_BUSY = 2'b10
  } slvc_vpd_state_t;

endpackage : slvc_pkg

/* File: core/slvc_regs.sv */
// Behaviour
// - slot control bits 0..4 are read-write event enables, cleared at reset
// - slot control bit 5 is hot-plug interrupt master enable, reset zero
// - tuning-0 bit 2 enables cross-link, reset zero
// - tuning-0 bit 3 read-write; setting it sends training to Configuration
// - tuning-0 bit 4 selects internal debug mode, reset zero
// - tuning-0 bits 7:5 lane retry count reset 3, bits 12:8 TS1 count reset 16
// - tuning-0 bits 31:16 hold L1 entry timer default, reset 0x0400
// - tuning-2 bits 7:0 clock-recovery time in FTS sets, reset 0x54
// - tuning-2 bits 14:8 L0s exit latency, read-write, reset 2
// - tuning-2 bits 22:16 L1 exit latency, read-write, reset 0x19
// - tuning-2 bit 15 inverts the receive pair polarity, reset zero
// - wait period 0..127 means 128.. ms, 128..255 means 0..127 ms
// - capability dword at 0xD8 returns identifier 0x03 in bits 7:0
// - bits 15:8 of that dword return next pointer 0xF0
// - writing bit 31 as 0 starts EEPROM read; bit reads 0, then 1
// - writing bit 31 as 1 starts EEPROM write; bit reads 1, then 0
// - EEPROM location is the programmed address plus 0x40
// - data register low byte is the addressed byte; byte-enabled access
// - slot bits only mean anything with hot-plug strapped in reverse mode
`timescale 1ns/1ps
`include "slvc_defines.svh"

module slvc_regs
  import slvc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // configuration access
  input  wire logic        cfgRead,
  input  wire logic        cfgWrite,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWriteData,
  output logic      [31:0] cfgReadData,
  output logic             cfgReadValid,
  // strap pins
  input  wire logic        hotPlugStrap,
  input  wire logic        reverseStrap,
  // hot-plug slot pins: button, fault, latch chg, presence chg, cmd done, latch, presence
  input  wire logic [6:0]  slotEvents,
  output logic      [15:0] slotControl,
  output logic             hotPlugIntEnable,
  // link physical layer tuning
  output logic      [31:0] linkTuning0,
  output logic      [31:0] linkTuning1,
  output logic      [23:0] linkTuning2,
  output logic             crossLinkEnable,
  output logic             debugModeSelect,
  output logic             gotoConfigPulse,
  output logic             receivePairInvert,
  output logic      [8:0]  l1WaitMs,
  // eeprom controller
  output logic             eepromReq,
  output logic             eepromWrite,
  output logic      [8:0]  eepromAddr,
  output logic      [31:0] eepromWriteData,
  input  wire logic        eepromAck,
  input  wire logic [31:0] eepromReadData
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic hitAddr(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction : hitAddr

  function automatic logic [31:0] laneMask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : laneMask

  // byte-enabled merge that never touches reserved bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] m;
    m = laneMask(be) & wmask;
    return (old & ~m) | (wd & m);
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // strap and slot pin synchronisers

  logic [1:0] strapMeta;
  logic [1:0] strapSync;
  logic [6:0] slotMeta;
  logic [6:0] slotSync;
  logic       strapTaken;
  logic       hpActive;
  logic [6:0] slotStatus;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strapMeta <= 2'h0;
      strapSync <= 2'h0;
      slotMeta  <= 7'h00;
      slotSync  <= 7'h00;
    end else begin
      strapMeta <= {reverseStrap, hotPlugStrap};
      strapSync <= strapMeta;
      slotMeta  <= slotEvents;
      slotSync  <= slotMeta;
    end
  end

  // straps caught once, after the synchroniser has filled past reset
  logic [1:0] strapWait;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strapWait  <= 2'b00;
      strapTaken <= 1'b0;
      hpActive   <= 1'b0;
    end else begin
      strapWait <= {strapWait[0], 1'b1};
      if (strapWait[1] && !strapTaken) begin
        strapTaken <= 1'b1;
        hpActive   <= strapSync[0] & strapSync[1];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slotStatus <= 7'h00;
    end else begin
      slotStatus <= hpActive ? slotSync : 7'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write strobes

  logic wrSlot;
  logic wrLt0;
  logic wrLt1;
  logic wrD4;
  logic wrVpdCtrl;
  logic wrVpdData;

  assign wrSlot    = cfgWrite && hitAddr(cfgAddr, `SLVC_OFF_SLOT);
  assign wrLt0     = cfgWrite && hitAddr(cfgAddr, `SLVC_OFF_LT0);
  assign wrLt1     = cfgWrite && hitAddr(cfgAddr, `SLVC_OFF_LT1);
  assign wrD4      = cfgWrite && hitAddr(cfgAddr, `SLVC_OFF_LT2);
  assign wrVpdCtrl = cfgWrite && hitAddr(cfgAddr, `SLVC_OFF_VPD_CTRL);
  assign wrVpdData = cfgWrite && hitAddr(cfgAddr, `SLVC_OFF_PRODUCT_DATA_WORD);

  ////////////////////////////////////////////////////////////////////////////
  // slot control

  logic [31:0] slotMerged;
  assign slotMerged = merge({16'h0000, slotControl}, cfgWriteData, cfgByteEn,
                            {16'h0000, `SLVC_SLOT_CTRL_WMASK});

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slotControl <= `SLVC_SLOT_CTRL_RST;
    end else if (wrSlot) begin
      slotControl <= slotMerged[15:0];
    end
  end

  // no hot-plug interrupt unless software armed it on a strapped slot
  assign hotPlugIntEnable = slotControl[`SLVC_SLOT_HP_INT_EN] & hpActive;

  ////////////////////////////////////////////////////////////////////////////
  // link tuning registers

  logic [31:0] lt0Merged;
  logic [31:0] d4Merged;
  logic [7:0]  waitPeriod;

  assign lt0Merged = merge(linkTuning0, cfgWriteData, cfgByteEn, `SLVC_LT0_WMASK);
  assign d4Merged  = merge({waitPeriod, linkTuning2}, cfgWriteData, cfgByteEn,
                           `SLVC_D4_WMASK);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      linkTuning0     <= `SLVC_LT0_RST;
      gotoConfigPulse <= 1'b0;
    end else begin
      gotoConfigPulse <= 1'b0;
      if (wrLt0) begin
        linkTuning0     <= lt0Merged;
        // only a fresh set restarts training; rewriting a 1 does nothing
        gotoConfigPulse <= lt0Merged[`SLVC_LT0_GOTO_CFG] &
                           ~linkTuning0[`SLVC_LT0_GOTO_CFG];
      end
    end
  end

  assign crossLinkEnable = linkTuning0[`SLVC_LT0_CROSS_LINK];
  assign debugModeSelect = linkTuning0[`SLVC_LT0_DEBUG_SEL];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      linkTuning1 <= `SLVC_LT1_RST;
    end else if (wrLt1) begin
      linkTuning1 <= merge(linkTuning1, cfgWriteData, cfgByteEn, `SLVC_LT1_WMASK);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      linkTuning2 <= `SLVC_LT2_RST;
      waitPeriod  <= `SLVC_WAIT_RST;
    end else if (wrD4) begin
      linkTuning2 <= d4Merged[23:0];
      waitPeriod  <= d4Merged[31:24];
    end
  end

  assign receivePairInvert = linkTuning2[`SLVC_LT2_RX_INVERT];

  // low half of the code space maps to the long waits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      l1WaitMs <= `SLVC_WAIT_MS_RST;
    end else begin
      l1WaitMs <= waitPeriod[7] ? {2'b00, waitPeriod[6:0]} : {2'b01, waitPeriod[6:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // product data capability and eeprom sequencer

  slvc_vpd_state_t vpdState;
  logic [5:0]      vpdAddr;
  logic            vpdFlag;
  logic [31:0]     vpdData;
  logic [5:0]      startAddr;
  logic            vpdStart;

  // address and operation locked while a cycle runs, so the flag stays honest
  assign vpdStart  = wrVpdCtrl && cfgByteEn[3] && (vpdState == VPD_IDLE);
  assign startAddr = cfgByteEn[2] ? cfgWriteData[`SLVC_VPD_ADDR_MSB:`SLVC_VPD_ADDR_LSB]
                                  : vpdAddr;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vpdState        <= VPD_IDLE;
      vpdAddr         <= 6'h00;
      vpdFlag         <= 1'b0;
      eepromReq       <= 1'b0;
      eepromWrite     <= 1'b0;
      eepromAddr      <= 9'h000;
      eepromWriteData <= 32'h0000_0000;
    end else begin
      unique case (vpdState)
        VPD_IDLE: begin
          if (wrVpdCtrl && cfgByteEn[2]) begin
            vpdAddr <= startAddr;
          end
          if (vpdStart) begin
            vpdState        <= VPD_BUSY;
            vpdFlag         <= cfgWriteData[`SLVC_VPD_OP_BIT];
            eepromReq       <= 1'b1;
            eepromWrite     <= cfgWriteData[`SLVC_VPD_OP_BIT];
            eepromAddr      <= {1'b0, startAddr, 2'b00} + `SLVC_EEPROM_BASE;
            eepromWriteData <= vpdData;
          end
        end
        VPD_BUSY: begin
          if (eepromAck) begin
            vpdState  <= VPD_IDLE;
            eepromReq <= 1'b0;
            vpdFlag   <= ~vpdFlag;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vpdData <= `SLVC_PRODUCT_DATA_WORD_RST;
    end else if (vpdState == VPD_BUSY && eepromAck && !eepromWrite) begin
      vpdData <= eepromReadData;
    end else if (wrVpdData && vpdState == VPD_IDLE) begin
      vpdData <= merge(vpdData, cfgWriteData, cfgByteEn, 32'hFFFF_FFFF);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path; unmapped dwords answer zero

  logic [31:0] readValue;

  always_comb begin
    readValue = 32'h0000_0000;
    if (hitAddr(cfgAddr, `SLVC_OFF_SLOT)) begin
      readValue = {9'h000, slotStatus, slotControl};
    end else if (hitAddr(cfgAddr, `SLVC_OFF_LT0)) begin
      readValue = linkTuning0;
    end else if (hitAddr(cfgAddr, `SLVC_OFF_LT1)) begin
      readValue = linkTuning1;
    end else if (hitAddr(cfgAddr, `SLVC_OFF_LT2)) begin
      readValue = {waitPeriod, linkTuning2};
    end else if (hitAddr(cfgAddr, `SLVC_OFF_VPD_CTRL)) begin
      readValue = {vpdFlag, 7'h00, vpdAddr, 2'b00,
                   `SLVC_VPD_NEXT_PTR, `SLVC_VPD_CAP_ID};
    end else if (hitAddr(cfgAddr, `SLVC_OFF_PRODUCT_DATA_WORD)) begin
      readValue = vpdData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgReadData  <= 32'h0000_0000;
      cfgReadValid <= 1'b0;
    end else begin
      cfgReadValid <= cfgRead;
      if (cfgRead) begin
        cfgReadData <= readValue;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_CAP_HEADER: assert property (
    cfgRead && hitAddr(cfgAddr, `SLVC_OFF_VPD_CTRL)
      |=> cfgReadValid && cfgReadData[15:0] == 16'hF003 && cfgReadData[30:24] == 7'h00)
    else $error("capability header read wrong");

  AST_READ_START: assert property (
    vpdStart && !cfgWriteData[31] |=> vpdState == VPD_BUSY && !vpdFlag && eepromReq)
    else $error("read cycle did not start with flag low");

  AST_BUSY_HOLD: assert property (
    vpdState == VPD_BUSY && !eepromAck |=> vpdState == VPD_BUSY && $stable(vpdFlag)
      && eepromReq)
    else $error("flag or request moved while cycle runs");

  AST_READ_DONE: assert property (
    vpdState == VPD_BUSY && eepromAck && !eepromWrite
      |=> vpdFlag && vpdState == VPD_IDLE && vpdData == $past(eepromReadData))
    else $error("read completion wrong");

  AST_WRITE_DONE: assert property (
    vpdState == VPD_BUSY && eepromAck && eepromWrite |=> !vpdFlag && !eepromReq)
    else $error("write completion wrong");

  AST_EE_ADDR: assert property (
    eepromReq |-> eepromAddr == {1'b0, vpdAddr, 2'b00} + 9'h040)
    else $error("eeprom address not offset");

  AST_STATUS_GATE: assert property (
    !hpActive |-> !hotPlugIntEnable ##1 slotStatus == 7'h00)
    else $error("slot status visible without hot-plug");

  AST_GOTO_CFG: assert property (
    gotoConfigPulse |-> linkTuning0[3] && !$past(linkTuning0[3]) ##1 !gotoConfigPulse)
    else $error("configuration jump pulse wrong");

  AST_L1_DECODE: assert property (
    1'b1 |=> l1WaitMs == {1'b0, $past(waitPeriod) ^ 8'h80})
    else $error("wait period decode wrong");

  AST_RSVD_LT0: assert property (
    cfgRead && hitAddr(cfgAddr, `SLVC_OFF_LT0) |=> cfgReadData[15:13] == 3'h0)
    else $error("reserved tuning bits not zero");

endmodule : slvc_regs

/* File: tb/slvc_eeprom_model.sv */
`timescale 1ns/1ps

module slvc_eeprom_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // request side
  input  wire logic        eepromReq,
  input  wire logic        eepromWrite,
  input  wire logic [8:0]  eepromAddr,
  input  wire logic [31:0] eepromWriteData,
  input  wire logic [3:0]  latency,
  // answer side
  output logic             eepromAck,
  output logic      [31:0] eepromReadData
);
  logic [31:0] mem [0:127];
  logic [3:0]  cnt;
  logic        done;

  ////////////////////////////////////////////////////////////////////////////////
  // one ack per request; data toggles outside the ack so stale values never match
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt            <= 4'h0;
      done           <= 1'b0;
      eepromAck      <= 1'b0;
      eepromReadData <= 32'h0000_0000;
    end else begin
      eepromAck      <= 1'b0;
      eepromReadData <= ~eepromReadData;
      if (!eepromReq) begin
        cnt  <= 4'h0;
        done <= 1'b0;
      end else if (!done && cnt == latency) begin
        eepromAck <= 1'b1;
        done      <= 1'b1;
        if (eepromWrite) begin
          mem[eepromAddr[8:2]] <= eepromWriteData;
        end else begin
          eepromReadData <= mem[eepromAddr[8:2]];
        end
      end else if (!done) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : slvc_eeprom_model

/* File: tb/tb_slot_link_vpd_config_regs.sv */
`timescale 1ns/1ps

module tb_slot_link_vpd_config_regs;
  import slvc_pkg::*;
  logic        clk = 1'b0, reset_n = 1'b0, cfgRead = 1'b0, cfgWrite = 1'b0;
  logic [7:0]  cfgAddr = 8'h00;
  logic [3:0]  cfgByteEn = 4'h0, lat = 4'h0;
  logic [31:0] cfgWriteData = 32'h0, cfgReadData, d, eRd, eWd, linkTuning0, linkTuning1;
  logic [15:0] slotControl;
  logic [23:0] linkTuning2;
  logic [8:0]  l1WaitMs, eAddr;
  logic [6:0]  slotEvents = 7'h00;
  logic [1:0]  straps = 2'b11;
  logic        cfgReadValid, hpIe, xLink, dbg, gotoCfg, rxInv, eReq, eWr, eAck;
  int          err_count = 0, n_tests = 0, cyc = 0;
  logic [7:0]  adr [6] = '{8'hC8, 8'hCC, 8'hD0, 8'hD4, 8'hD8, 8'hDC};
  logic [31:0] rv  [6] = '{32'h0, 32'h0400_1060, 32'h0, 32'h0019_0254, 32'h0000_F003, 32'h0};
  logic [31:0] wm  [6] = '{32'h0000_07FF, 32'hFFFF_1FFF, 32'hFFFF_03FF, 32'hFF7F_FFFF,
                           32'h0, 32'h0};
  logic [7:0]  wv  [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
  logic [8:0]  ms  [4] = '{9'h080, 9'h0FF, 9'h000, 9'h07F};

  always #5 clk = ~clk;

  slvc_regs i_slvc_regs (
    .clk(clk), .reset_n(reset_n), .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
    .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
    .cfgReadValid(cfgReadValid), .hotPlugStrap(straps[0]), .reverseStrap(straps[1]),
    .slotEvents(slotEvents), .slotControl(slotControl), .hotPlugIntEnable(hpIe),
    .linkTuning0(linkTuning0), .linkTuning1(linkTuning1), .linkTuning2(linkTuning2),
    .crossLinkEnable(xLink), .debugModeSelect(dbg), .gotoConfigPulse(gotoCfg),
    .receivePairInvert(rxInv), .l1WaitMs(l1WaitMs), .eepromReq(eReq), .eepromWrite(eWr),
    .eepromAddr(eAddr), .eepromWriteData(eWd), .eepromAck(eAck), .eepromReadData(eRd));

  slvc_eeprom_model i_slvc_eeprom_model (
    .clk(clk), .reset_n(reset_n), .eepromReq(eReq), .eepromWrite(eWr), .eepromAddr(eAddr),
    .eepromWriteData(eWd), .latency(lat), .eepromAck(eAck), .eepromReadData(eRd));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("counts: %0d checks, %0d bad", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
    @(posedge clk);
    #1;
    cfgWrite = 1'b1;
    cfgAddr = a;
    cfgByteEn = be;
    cfgWriteData = v;
    @(posedge clk);
    #1 cfgWrite = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    #1;
    cfgRead = 1'b1;
    cfgAddr = a;
    @(posedge clk);
    #1 cfgRead = 1'b0;
    check("readValid", {31'h0, cfgReadValid}, 32'h1);
    v = cfgReadData;
  endtask : rd

  // slow cycles leave time to look at the busy flag and try a refused write
  task automatic vpd(input logic op, input logic [3:0] l, input logic slow);
    int n;
    lat = l;
    wr(8'hD8, 4'hC, {op, 7'h0, 6'h01, 18'h0});
    check("eepromAddr", {23'h0, eAddr}, 32'h0000_0044);
    check("eepromWrite", {31'h0, eWr}, {31'h0, op});
    if (op) check("eepromWriteData", eWd, 32'hA5A5_1234);
    if (slow) begin
      rd(8'hD8, d);
      check("busyFlag", d, {op, 7'h0, 6'h01, 18'h0F003});
      wr(8'hDC, 4'hF, 32'hDEAD_0000);
    end
    n = 0;
    while (eReq === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    rd(8'hD8, d);
    check("doneFlag", d, {~op, 7'h0, 6'h01, 18'h0F003});
    rd(8'hDC, d);
    check("dataWord", d, 32'hA5A5_1234);
  endtask : vpd

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(adr[i], d);
      check("resetValue", d, rv[i]);
    end
    check("waitMsReset", {23'h0, l1WaitMs}, 32'h80);
    $display("test reset values done");

    wr(8'hCC, 4'hF, 32'hFFFF_FFFF);
    check("gotoConfig", {31'h0, gotoCfg}, 32'h1);
    @(posedge clk);
    #1 check("gotoConfigEnd", {31'h0, gotoCfg}, 32'h0);
    for (int i = 0; i < 4; i++) wr(adr[i], 4'hF, 32'hFFFF_FFFF);
    wr(8'hE0, 4'hF, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++) begin
      rd(adr[i], d);
      check("writeMask", d, wm[i]);
    end
    rd(8'hE0, d);
    check("unmapped", d, 32'h0);
    check("enables", {28'h0, hpIe, xLink, dbg, rxInv}, 32'hF);
    check("lt0Port", linkTuning0, 32'hFFFF_1FFF);
    check("lt1Port", linkTuning1, 32'hFFFF_03FF);
    check("lt2Port", {8'h0, linkTuning2}, 32'h007F_FFFF);
    check("slotCtrlPort", {16'h0, slotControl}, 32'h0000_07FF);
    wr(8'hCC, 4'h1, 32'h0);
    rd(8'hCC, d);
    check("byteLane", d, 32'hFFFF_1F00);
    $display("test write masks done");

    for (int i = 0; i < 4; i++) begin
      wr(8'hD4, 4'h8, {wv[i], 24'h0});
      @(posedge clk);
      #1 check("waitMs", {23'h0, l1WaitMs}, {23'h0, ms[i]});
    end
    slotEvents = 7'h55;
    repeat (6) @(posedge clk);
    rd(8'hC8, d);
    check("slotStatus", d, 32'h0055_07FF);
    $display("test decode and status done");

    wr(8'hDC, 4'hF, 32'hA5A5_1234);
    vpd(1'b1, 4'hA, 1'b1);
    wr(8'hDC, 4'hF, 32'h0);
    vpd(1'b0, 4'h0, 1'b0);
    vpd(1'b0, 4'hC, 1'b1);
    wr(8'hDC, 4'h1, 32'h0000_00FF);
    rd(8'hDC, d);
    check("dataLane", d, 32'hA5A5_12FF);
    $display("test eeprom cycles done");

    // second reset with the reverse strap low: slot logic must stay dark
    straps = 2'b01;
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    check("waitMsReset2", {23'h0, l1WaitMs}, 32'h80);
    rd(8'hCC, d);
    check("lt0Reset2", d, 32'h0400_1060);
    rd(8'hD4, d);
    check("d4Reset2", d, 32'h0019_0254);
    repeat (4) @(posedge clk);
    wr(8'hC8, 4'hF, 32'hFFFF_FFFF);
    rd(8'hC8, d);
    check("slotGated", d, 32'h0000_07FF);
    check("intGated", {31'h0, hpIe}, 32'h0);
    $display("test strap gating done");
    results();
  end
endmodule : tb_slot_link_vpd_config_regs
